// ==== rtl/pmsca_pkg.sv ====
// constants, field layout and state codes for the pmbus store/capability/alert-mask block
// Function
// - command 0x12 reloads all working settings from the factory default store
// - command 0x15 saves settings changed since last restore into user store
// - command 0x16 reloads user store; also done automatically at power-up
// - read of command 0x19 returns one capability byte
// - capability bit 7 set when packet error checking is supported
// - capability bits 6:5 give top bus speed: 00 100k, 01 400k, 10 1M
// - capability bit 4 set when alert output and alert response exist
// - capability bit 3 clear for linear/direct, set for half-precision float
// - command 0x1B holds alert masks; mask bit 1 suppresses, 0 lets alert through
// - one mask byte gates alerts of output-voltage status register 0x7A
// - a separate mask byte gates alerts of output-current status register 0x7B
package pmsca_pkg;
  // command codes
  localparam logic [7:0] CMD_RESTORE_DEFAULT = 8'h12;
  localparam logic [7:0] CMD_STORE_USER      = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER    = 8'h16;
  localparam logic [7:0] CMD_CAPABILITY      = 8'h19;
  localparam logic [7:0] CMD_ALERT_MASK      = 8'h1b;
  // status register codes used as mask selectors
  localparam logic [7:0] STATUS_VOUT_CODE    = 8'h7a;
  localparam logic [7:0] STATUS_IOUT_CODE    = 8'h7b;
  // bus address of this device
  localparam logic [6:0] DEV_ADDR            = 7'h40;
  // capability field positions
  localparam int         CAP_PEC_POS         = 7;
  localparam int         CAP_SPEED_HI        = 6;
  localparam int         CAP_SPEED_LO        = 5;
  localparam int         CAP_ALERT_POS       = 4;
  localparam int         CAP_FMT_POS         = 3;
  localparam int         CAP_AVS_POS         = 2;
  // capability field values
  // no packet error checking
  localparam logic       CAP_PEC             = 1'b0;
  localparam logic [1:0] CAP_SPEED           = 2'h1;
  localparam logic       CAP_ALERT           = 1'b1;
  localparam logic       CAP_FMT             = 1'b0;
  localparam logic       CAP_AVS             = 1'b0;
  localparam logic [7:0] CAP_BYTE            = {CAP_PEC, CAP_SPEED, CAP_ALERT, CAP_FMT,
                                                CAP_AVS, 2'h0};
  // factory default and blank user store values
  localparam logic [7:0] DEFAULT_VOUT_MASK   = 8'h00;
  localparam logic [7:0] DEFAULT_IOUT_MASK   = 8'h00;
  localparam logic [7:0] USER_RESET_MASK     = 8'h00;
  // byte framing
  localparam logic [3:0] BITS_PER_BYTE       = 4'h8;
  localparam logic [1:0] IDX_ADDR            = 2'h0;
  localparam logic [1:0] IDX_CMD             = 2'h1;
  localparam logic [1:0] IDX_DATA0           = 2'h2;
  localparam logic [1:0] IDX_DATA1           = 2'h3;

  // bit-level protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_TACK = 3'b100,
    ST_WAIT = 3'b101
  } pmsca_state_t;
endpackage : pmsca_pkg

// ==== rtl/pmsca_top.sv ====
// pmbus slave for store/restore commands, capability byte and vout/iout alert masks
`timescale 1ns/1ps
module pmsca_top (
  // system clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bus clock pin, clocks the link capture flop
  input  wire logic       pmbus_clk,
  // bus data pin, open drain
  input  wire logic       pmbus_data_in,
  output logic            pmbus_data_out,
  output logic            pmbus_data_oe,
  // alert pin, open drain
  output logic            alert_output_out,
  output logic            alert_output_oe,
  // status registers from the monitoring logic
  input  wire logic [7:0] vout_status,
  input  wire logic [7:0] iout_status,
  // working masks seen by the rest of the device
  output logic [7:0]      vout_alert_mask,
  output logic [7:0]      iout_alert_mask
);

  // link domain: data bit captured on each rising bus clock
  logic link_bit;
  always_ff @(posedge pmbus_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_bit <= 1'b0;
    end else begin
      link_bit <= pmbus_data_in;
    end
  end

  // pin synchronisers into the system domain
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= pmbus_clk;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= pmbus_data_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // bus events; link_bit has settled at least one cycle before scl_rise is seen
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise   = scl_s2 & ~scl_s3;
  assign scl_fall   = ~scl_s2 & scl_s3;
  assign start_cond = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
  assign stop_cond  = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

  // protocol and configuration state
  pmsca_pkg::pmsca_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [1:0] byte_idx, next_byte_idx;
  logic [7:0] shreg, next_shreg;
  logic [7:0] cmd, next_cmd;
  logic [7:0] sel, next_sel;
  logic       cmd_valid, next_cmd_valid;
  logic       is_read, next_is_read;
  logic       sda_oe, next_sda_oe;
  logic [7:0] vout_mask, next_vout_mask;
  logic [7:0] iout_mask, next_iout_mask;
  logic [7:0] user_vout, next_user_vout;
  logic [7:0] user_iout, next_user_iout;
  logic [1:0] dirty, next_dirty;
  logic       boot_pending, next_boot_pending;
  logic       alert_oe, next_alert_oe;
  logic       exec_now, load_tx, wr_vout, wr_iout, ack;
  logic [7:0] tx_byte;

  // byte returned on a read, chosen by the latched command and selector
  always_comb begin
    tx_byte = 8'h00;
    if (cmd == pmsca_pkg::CMD_CAPABILITY) begin
      tx_byte = pmsca_pkg::CAP_BYTE;
    end else if (sel == pmsca_pkg::STATUS_VOUT_CODE) begin
      tx_byte = vout_mask;
    end else if (sel == pmsca_pkg::STATUS_IOUT_CODE) begin
      tx_byte = iout_mask;
    end
  end

  // next-state logic for the protocol engine and the settings
  always_comb begin
    next_state        = state;
    next_bit_cnt      = bit_cnt;
    next_byte_idx     = byte_idx;
    next_shreg        = shreg;
    next_cmd          = cmd;
    next_sel          = sel;
    next_cmd_valid    = cmd_valid;
    next_is_read      = is_read;
    next_sda_oe       = sda_oe;
    next_vout_mask    = vout_mask;
    next_iout_mask    = iout_mask;
    next_user_vout    = user_vout;
    next_user_iout    = user_iout;
    next_dirty        = dirty;
    next_boot_pending = 1'b0;
    exec_now          = 1'b0;
    load_tx           = 1'b0;
    wr_vout           = 1'b0;
    wr_iout           = 1'b0;
    ack               = 1'b0;
    // send-byte commands run at the stop that ends a bare command frame
    if (stop_cond && state != pmsca_pkg::ST_IDLE && cmd_valid && !is_read &&
        byte_idx == pmsca_pkg::IDX_DATA0) begin
      exec_now = 1'b1;
    end
    if (start_cond) begin
      next_state    = pmsca_pkg::ST_RX;
      next_bit_cnt  = 4'h0;
      next_byte_idx = pmsca_pkg::IDX_ADDR;
      next_is_read  = 1'b0;
      next_sda_oe   = 1'b0;
    end else if (stop_cond) begin
      next_state     = pmsca_pkg::ST_IDLE;
      next_cmd_valid = 1'b0;
      next_sda_oe    = 1'b0;
    end else begin
      case (state)
        pmsca_pkg::ST_RX: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], link_bit};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == pmsca_pkg::BITS_PER_BYTE) begin
            case (byte_idx)
              pmsca_pkg::IDX_ADDR: begin
                next_is_read = shreg[0];
                ack = (shreg[7:1] == pmsca_pkg::DEV_ADDR) &&
                      (!shreg[0] || (cmd_valid &&
                       (cmd == pmsca_pkg::CMD_CAPABILITY ||
                        (cmd == pmsca_pkg::CMD_ALERT_MASK && byte_idx == 2'h0 &&
                         (sel == pmsca_pkg::STATUS_VOUT_CODE ||
                          sel == pmsca_pkg::STATUS_IOUT_CODE)))));
              end
              pmsca_pkg::IDX_CMD: begin
                ack = shreg == pmsca_pkg::CMD_RESTORE_DEFAULT ||
                      shreg == pmsca_pkg::CMD_STORE_USER ||
                      shreg == pmsca_pkg::CMD_RESTORE_USER ||
                      shreg == pmsca_pkg::CMD_CAPABILITY ||
                      shreg == pmsca_pkg::CMD_ALERT_MASK;
                next_cmd       = shreg;
                next_cmd_valid = ack;
              end
              pmsca_pkg::IDX_DATA0: begin
                ack = cmd == pmsca_pkg::CMD_ALERT_MASK &&
                      (shreg == pmsca_pkg::STATUS_VOUT_CODE ||
                       shreg == pmsca_pkg::STATUS_IOUT_CODE);
                next_sel = shreg;
              end
              default: begin
                ack     = cmd == pmsca_pkg::CMD_ALERT_MASK;
                wr_vout = ack && sel == pmsca_pkg::STATUS_VOUT_CODE;
                wr_iout = ack && sel == pmsca_pkg::STATUS_IOUT_CODE;
              end
            endcase
            next_sda_oe   = ack;
            next_state    = ack ? pmsca_pkg::ST_ACK : pmsca_pkg::ST_WAIT;
            next_bit_cnt  = 4'h0;
            next_byte_idx = (byte_idx == pmsca_pkg::IDX_DATA1) ? byte_idx
                                                               : byte_idx + 2'h1;
          end
        end
        pmsca_pkg::ST_ACK: begin
          if (scl_fall && is_read) begin
            load_tx      = 1'b1;
            next_shreg   = tx_byte;
            next_sda_oe  = ~tx_byte[7];
            next_bit_cnt = 4'h1;
            next_state   = pmsca_pkg::ST_TX;
          end else if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state  = pmsca_pkg::ST_RX;
          end
        end
        pmsca_pkg::ST_TX: begin
          if (scl_fall && bit_cnt == pmsca_pkg::BITS_PER_BYTE) begin
            next_sda_oe = 1'b0;
            next_state  = pmsca_pkg::ST_TACK;
          end else if (scl_fall) begin
            next_shreg   = {shreg[6:0], 1'b0};
            next_sda_oe  = ~shreg[6];
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end
        pmsca_pkg::ST_TACK: begin
          // master ack repeats the byte, nack ends the read
          if (scl_rise) begin
            next_state = link_bit ? pmsca_pkg::ST_WAIT : pmsca_pkg::ST_ACK;
          end
        end
        pmsca_pkg::ST_WAIT: begin
          next_sda_oe = 1'b0;
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
    if (wr_vout) begin
      next_vout_mask = shreg;
      next_dirty[0]  = 1'b1;
    end
    if (wr_iout) begin
      next_iout_mask = shreg;
      next_dirty[1]  = 1'b1;
    end
    if (boot_pending) begin
      next_vout_mask = user_vout;
      next_iout_mask = user_iout;
      next_dirty     = 2'h0;
    end else if (exec_now) begin
      case (cmd)
        pmsca_pkg::CMD_RESTORE_DEFAULT: begin
          next_vout_mask = pmsca_pkg::DEFAULT_VOUT_MASK;
          next_iout_mask = pmsca_pkg::DEFAULT_IOUT_MASK;
          next_dirty     = 2'h0;
        end
        pmsca_pkg::CMD_STORE_USER: begin
          if (dirty[0]) begin
            next_user_vout = vout_mask;
          end
          if (dirty[1]) begin
            next_user_iout = iout_mask;
          end
          next_dirty = 2'h0;
        end
        pmsca_pkg::CMD_RESTORE_USER: begin
          next_vout_mask = user_vout;
          next_iout_mask = user_iout;
          next_dirty     = 2'h0;
        end
        default: begin
          next_dirty = dirty;
        end
      endcase
    end
    next_alert_oe = |(vout_status & ~vout_mask) | |(iout_status & ~iout_mask);
  end

  // register stage for all protocol and settings state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= pmsca_pkg::ST_IDLE;
      bit_cnt      <= 4'h0;
      byte_idx     <= 2'h0;
      shreg        <= 8'h00;
      cmd          <= 8'h00;
      sel          <= 8'h00;
      cmd_valid    <= 1'b0;
      is_read      <= 1'b0;
      sda_oe       <= 1'b0;
      vout_mask    <= pmsca_pkg::DEFAULT_VOUT_MASK;
      iout_mask    <= pmsca_pkg::DEFAULT_IOUT_MASK;
      user_vout    <= pmsca_pkg::USER_RESET_MASK;
      user_iout    <= pmsca_pkg::USER_RESET_MASK;
      dirty        <= 2'h0;
      boot_pending <= 1'b1;
      alert_oe     <= 1'b0;
    end else begin
      state        <= next_state;
      bit_cnt      <= next_bit_cnt;
      byte_idx     <= next_byte_idx;
      shreg        <= next_shreg;
      cmd          <= next_cmd;
      sel          <= next_sel;
      cmd_valid    <= next_cmd_valid;
      is_read      <= next_is_read;
      sda_oe       <= next_sda_oe;
      vout_mask    <= next_vout_mask;
      iout_mask    <= next_iout_mask;
      user_vout    <= next_user_vout;
      user_iout    <= next_user_iout;
      dirty        <= next_dirty;
      boot_pending <= next_boot_pending;
      alert_oe     <= next_alert_oe;
    end
  end

  // pins: open drain, only ever pulled low
  logic pin_low;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_low <= 1'b0;
    end else begin
      pin_low <= 1'b0;
    end
  end
  assign pmbus_data_out   = pin_low;
  assign pmbus_data_oe    = sda_oe;
  assign alert_output_out = pin_low;
  assign alert_output_oe  = alert_oe;
  assign vout_alert_mask  = vout_mask;
  assign iout_alert_mask  = iout_mask;

  // checks on the system domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_restore_default;
    exec_now && !boot_pending && cmd == pmsca_pkg::CMD_RESTORE_DEFAULT |=>
      vout_mask == pmsca_pkg::DEFAULT_VOUT_MASK && iout_mask == pmsca_pkg::DEFAULT_IOUT_MASK;
  endproperty
  a_restore_default: assert property (p_restore_default) else $error("defaults lost");
  property p_store_user;
    exec_now && !boot_pending && cmd == pmsca_pkg::CMD_STORE_USER && dirty[0] |=>
      user_vout == $past(vout_mask) && dirty == 2'h0;
  endproperty
  a_store_user: assert property (p_store_user) else $error("user store not updated");
  property p_restore_user;
    (exec_now && cmd == pmsca_pkg::CMD_RESTORE_USER) || boot_pending |=>
      vout_mask == $past(user_vout) && iout_mask == $past(user_iout);
  endproperty
  a_restore_user: assert property (p_restore_user) else $error("user reload missed");
  property p_cap_load;
    load_tx && cmd == pmsca_pkg::CMD_CAPABILITY |=>
      state == pmsca_pkg::ST_TX && shreg == pmsca_pkg::CAP_BYTE;
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("capability byte not loaded");
  property p_cap_pec;
    load_tx && cmd == pmsca_pkg::CMD_CAPABILITY |=> sda_oe == ~pmsca_pkg::CAP_PEC;
  endproperty
  a_cap_pec: assert property (p_cap_pec) else $error("pec bit wrong on wire");
  property p_cap_speed;
    load_tx && cmd == pmsca_pkg::CMD_CAPABILITY |=> shreg[6:5] == pmsca_pkg::CAP_SPEED;
  endproperty
  a_cap_speed: assert property (p_cap_speed) else $error("speed field wrong");
  property p_cap_alert;
    load_tx && cmd == pmsca_pkg::CMD_CAPABILITY |=> shreg[4] == pmsca_pkg::CAP_ALERT;
  endproperty
  a_cap_alert: assert property (p_cap_alert) else $error("alert field wrong");
  property p_cap_fmt;
    load_tx && cmd == pmsca_pkg::CMD_CAPABILITY |=> shreg[3] == pmsca_pkg::CAP_FMT;
  endproperty
  a_cap_fmt: assert property (p_cap_fmt) else $error("format field wrong");
  property p_alert_gate;
    ##1 alert_oe == (|($past(vout_status) & ~$past(vout_mask)) |
                     |($past(iout_status) & ~$past(iout_mask)));
  endproperty
  a_alert_gate: assert property (p_alert_gate) else $error("alert not gated by mask");
  property p_vout_wr;
    wr_vout && !boot_pending |=> vout_mask == $past(shreg) && $stable(iout_mask);
  endproperty
  a_vout_wr: assert property (p_vout_wr) else $error("vout mask write wrong");
  property p_iout_wr;
    wr_iout && !boot_pending |=> iout_mask == $past(shreg) && $stable(vout_mask);
  endproperty
  a_iout_wr: assert property (p_iout_wr) else $error("iout mask write wrong");
  property p_sel_read;
    load_tx && cmd == pmsca_pkg::CMD_ALERT_MASK && sel == pmsca_pkg::STATUS_IOUT_CODE |=>
      shreg == $past(iout_mask);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("selected mask not returned");

  // main scenarios
  c_cap_read: cover property (load_tx && cmd == pmsca_pkg::CMD_CAPABILITY);
  c_vout_wr:  cover property (wr_vout);
  c_store:    cover property (exec_now && cmd == pmsca_pkg::CMD_STORE_USER);
  c_alert:    cover property ($rose(alert_oe));
endmodule : pmsca_top

// ==== verification/pmsca_host.sv ====
// host controller model driving the bus clock and data pins
`timescale 1ns/1ps
module pmsca_host (
  // bus pins as driven and seen by the host
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_wire
);
  logic lclk;

  // link oscillator; scl only moves inside frames
  initial begin
    lclk     = 1'b0;
    scl      = 1'b1;
    sda_pull = 1'b0;
    forever #24 lclk = ~lclk;
  end

  // wait a number of link clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask : tick

  // start or repeated start, scl left low
  task automatic start_c();
    tick(3);
    sda_pull = 1'b0;
    tick(1);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start_c

  // stop, bus left idle high
  task automatic stop_c();
    tick(3);
    sda_pull = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask : stop_c

  // nine bits msb first; data set late in low phase, sampled at end of high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(3);
      sda_pull = ~tx[i];
      tick(1);
      scl = 1'b1;
      tick(4);
      rx[i] = sda_wire;
      scl = 1'b0;
    end
  endtask : xfer

  // frame of n bytes from b, optional repeated start and one byte read
  // status code as selector
  task automatic wr(input logic [31:0] b, input int n, input logic rd,
                    output logic [7:0] q, output logic ok);
    logic [8:0] r;
    ok = 1'b1;
    q  = 8'h00;
    start_c();
    for (int k = 0; k < n; k++) begin
      xfer({b[31-8*k -: 8], 1'b1}, r);
      ok &= ~r[0];
    end
    if (rd) begin
      start_c();
      xfer({b[31:25], 1'b1, 1'b1}, r);
      ok &= ~r[0];
      xfer(9'h1ff, r);
      q = r[8:1];
    end
    stop_c();
  endtask : wr
endmodule : pmsca_host

// ==== verification/tb.sv ====
// self-checking bench for the store, capability and alert-mask block
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] AW = {pmsca_pkg::DEV_ADDR, 1'b0};
  localparam logic [7:0] MK = pmsca_pkg::CMD_ALERT_MASK;
  localparam logic [7:0] SV = pmsca_pkg::STATUS_VOUT_CODE;
  localparam logic [7:0] SI = pmsca_pkg::STATUS_IOUT_CODE;
  logic       clk, rst_n, scl, sda_pull, sda_wire, ok;
  logic       data_out, data_oe, alert_out, alert_oe;
  logic [7:0] vout_status, iout_status, vmask, imask, q;
  int         error_cnt, samples_checked;
  int         cycles = 0;

  pmsca_top dut (
    .clk(clk), .rst_n(rst_n), .pmbus_clk(scl), .pmbus_data_in(sda_wire),
    .pmbus_data_out(data_out), .pmbus_data_oe(data_oe),
    .alert_output_out(alert_out), .alert_output_oe(alert_oe),
    .vout_status(vout_status), .iout_status(iout_status),
    .vout_alert_mask(vmask), .iout_alert_mask(imask)
  );
  pmsca_host host (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));

  // data wire with pull-up, low when either side pulls
  assign sda_wire = ~sda_pull & (~data_oe | data_out);

  // system clock 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  // send-byte command expected to be accepted
  task automatic cmd(input logic [7:0] c);
    host.wr({AW, c, 16'h0000}, 2, 1'b0, q, ok);
    chk1("command ack", 1'b1, ok);
  endtask : cmd

  // working masks at the ports and read back over the bus
  task automatic masks(input logic [7:0] v, input logic [7:0] i);
    @(negedge clk);
    chk8("vout mask port", v, vmask);
    chk8("iout mask port", i, imask);
    chk1("data pin level", 1'b0, data_out);
    host.wr({AW, MK, SV, 8'h00}, 3, 1'b1, q, ok);
    chk8("vout mask read", v, q);
    host.wr({AW, MK, SI, 8'h00}, 3, 1'b1, q, ok);
    chk8("iout mask read", i, q);
  endtask : masks

  // walk one status bit at a time through both registers
  task automatic scan(input logic [7:0] v, input logic [7:0] i);
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      vout_status = (k < 8) ? 8'h01 << k : 8'h00;
      iout_status = (k < 8) ? 8'h00 : 8'h01 << (k - 8);
      repeat (2) @(negedge clk);
      chk1("alert pin", (k < 8) ? ~v[k] : ~i[k - 8], alert_oe);
      chk1("alert pin level", 1'b0, alert_out);
    end
    vout_status = 8'h00;
    iout_status = 8'h00;
  endtask : scan

  // main sequence
  initial begin
    rst_n           = 1'b0;
    vout_status     = 8'h00;
    iout_status     = 8'h00;
    error_cnt       = 0;
    samples_checked = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    masks(8'h00, 8'h00);
    // capability byte fields
    host.wr({AW, pmsca_pkg::CMD_CAPABILITY, 16'h0000}, 2, 1'b1, q, ok);
    chk1("cap ack", 1'b1, ok);
    chk1("cap pec", pmsca_pkg::CAP_PEC, q[pmsca_pkg::CAP_PEC_POS]);
    chk8("cap speed", {6'h00, pmsca_pkg::CAP_SPEED},
         {6'h00, q[pmsca_pkg::CAP_SPEED_HI:pmsca_pkg::CAP_SPEED_LO]});
    chk1("cap alert", 1'b1, q[pmsca_pkg::CAP_ALERT_POS]);
    chk1("cap format", pmsca_pkg::CAP_FMT, q[pmsca_pkg::CAP_FMT_POS]);
    chk1("cap avs", pmsca_pkg::CAP_AVS, q[pmsca_pkg::CAP_AVS_POS]);
    // masks per status register gate the alert pin
    host.wr({AW, MK, SV, 8'ha5}, 4, 1'b0, q, ok);
    chk1("vout mask ack", 1'b1, ok);
    host.wr({AW, MK, SI, 8'h3c}, 4, 1'b0, q, ok);
    chk1("iout mask ack", 1'b1, ok);
    masks(8'ha5, 8'h3c);
    scan(8'ha5, 8'h3c);
    // refused selector, command and address leave masks alone
    host.wr({AW, MK, 8'h7c, 8'hff}, 4, 1'b0, q, ok);
    chk1("bad selector ack", 1'b0, ok);
    host.wr({AW, 8'h13, 16'h0000}, 2, 1'b0, q, ok);
    chk1("bad command ack", 1'b0, ok);
    host.wr({8'h42, MK, SV, 8'h00}, 4, 1'b0, q, ok);
    chk1("bad address ack", 1'b0, ok);
    host.wr({AW, pmsca_pkg::CMD_RESTORE_DEFAULT, 16'h0000}, 3, 1'b0, q, ok);
    masks(8'ha5, 8'h3c);
    // store, overwrite, restore user then defaults
    cmd(pmsca_pkg::CMD_STORE_USER);
    host.wr({AW, MK, SV, 8'h11}, 4, 1'b0, q, ok);
    masks(8'h11, 8'h3c);
    cmd(pmsca_pkg::CMD_RESTORE_USER);
    masks(8'ha5, 8'h3c);
    cmd(pmsca_pkg::CMD_RESTORE_DEFAULT);
    masks(pmsca_pkg::DEFAULT_VOUT_MASK, pmsca_pkg::DEFAULT_IOUT_MASK);
    scan(pmsca_pkg::DEFAULT_VOUT_MASK, pmsca_pkg::DEFAULT_IOUT_MASK);
    // nothing changed since restore, so store keeps user copy
    cmd(pmsca_pkg::CMD_STORE_USER);
    cmd(pmsca_pkg::CMD_RESTORE_USER);
    masks(8'ha5, 8'h3c);
    // only the changed mask goes to the user copy
    host.wr({AW, MK, SI, 8'h77}, 4, 1'b0, q, ok);
    cmd(pmsca_pkg::CMD_STORE_USER);
    cmd(pmsca_pkg::CMD_RESTORE_DEFAULT);
    cmd(pmsca_pkg::CMD_RESTORE_USER);
    masks(8'ha5, 8'h77);
    // second reset runs the power-up restore of a blank store
    @(negedge clk);
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    masks(pmsca_pkg::USER_RESET_MASK, pmsca_pkg::USER_RESET_MASK);
    final_report();
  end
endmodule : tb
